// File: logic/fru_host.sv
// Host controller end: makes the link clock, sends commands, collects read bytes
`timescale 1ns/100ps
`include "fru_map.svh"

module fru_host
    import fru_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    fru_if.host              link,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic [7:0]  cmd_op_i,
    input  wire logic [23:0] cmd_addr_i,
    input  wire logic [7:0]  cmd_len_i,
    output logic             rd_valid_o,
    input  wire logic        rd_ready_i,
    output logic [7:0]       rd_data_o,
    output logic             done_o,
    output logic             cut_o
);

    fru_host_st_t s;
    fru_host_st_t next_s;

    logic rise;
    logic fall;
    logic in_ready;

    // Free running link clock so the device sees chip select rise
    assign rise = (s.div == `FRU_SCLK_HALF) && !s.sclk;
    assign fall = (s.div == `FRU_SCLK_HALF) && s.sclk;

    fru_fifo #(
        .WIDTH (8),
        .DEPTH (16)
    ) u_fru_fifo (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (s.push),
        .in_ready_o  (in_ready),
        .in_data_i   (s.pdat),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o)
    );

    always_comb begin
        next_s      = s;
        next_s.so1  = link.so_line;
        next_s.so2  = s.so1;
        next_s.div  = s.div + 2'h1;
        next_s.done = 1'b0;
        next_s.push = 1'b0;
        if (s.div == `FRU_SCLK_HALF) begin
            next_s.div  = 2'h0;
            next_s.sclk = !s.sclk;
        end

        unique case (s.st)
            FRU_H_IDLE: begin
                if (cmd_valid_i && s.rdy) begin
                    next_s.rdy  = 1'b0;
                    next_s.cut  = 1'b0;
                    next_s.fin  = 1'b0;
                    next_s.left = cmd_len_i;
                    next_s.rd   = (cmd_op_i == `FRU_OPC_UID) || (cmd_op_i == `FRU_OPC_PTBL);
                    next_s.tx   = {cmd_op_i, 32'h0};
                    if (cmd_op_i == `FRU_OPC_PTBL) begin
                        next_s.tx = {cmd_op_i, cmd_addr_i, 8'h00};
                    end
                    next_s.st   = FRU_H_LOAD;
                end
            end
            FRU_H_LOAD: begin
                if (fall) begin
                    next_s.cs_n = 1'b0;
                    next_s.si   = s.tx[39];
                    next_s.tx   = {s.tx[38:0], 1'b0};
                    next_s.ecnt = 8'h00;
                    next_s.rxc  = 3'h0;
                    next_s.st   = FRU_H_XFER;
                end
            end
            FRU_H_XFER: begin
                if (rise) begin
                    if (s.ecnt != 8'hff) begin
                        next_s.ecnt = s.ecnt + 8'h01;
                    end
                    if (!s.rd && s.ecnt == 8'(`FRU_OPC_BITS - 6'h01)) begin
                        next_s.fin = 1'b1;
                    end
                    if (s.rd && !s.fin && s.ecnt >= `FRU_RX_EDGE) begin
                        next_s.rxb = {s.rxb[6:0], s.so2};
                        next_s.rxc = s.rxc + 3'h1;
                        if (s.rxc == 3'h7) begin
                            // Full buffer ends the read early
                            if (in_ready) begin
                                next_s.push = 1'b1;
                                next_s.pdat = {s.rxb[6:0], s.so2};
                                next_s.left = s.left - 8'h01;
                                next_s.fin  = (s.left == 8'h01);
                            end else begin
                                next_s.cut = 1'b1;
                                next_s.fin = 1'b1;
                            end
                        end
                    end
                end
                if (fall) begin
                    next_s.si = s.tx[39];
                    next_s.tx = {s.tx[38:0], 1'b0};
                    if (s.fin) begin
                        next_s.cs_n = 1'b1;
                        next_s.si   = 1'b0;
                        next_s.tail = 2'h0;
                        next_s.st   = FRU_H_TAIL;
                    end
                end
            end
            FRU_H_TAIL: begin
                // Device needs edges with chip select high to close its frame
                if (rise) begin
                    next_s.tail = s.tail + 2'h1;
                    if (s.tail == `FRU_TAIL_EDGES - 2'h1) begin
                        next_s.done = 1'b1;
                        next_s.rdy  = 1'b1;
                        next_s.st   = FRU_H_IDLE;
                    end
                end
            end
        endcase

        if (!rst_b_i) begin
            next_s      = '0;
            next_s.cs_n = 1'b1;
            next_s.st   = FRU_H_IDLE;
        end else if (s.st == FRU_H_IDLE && !s.rdy && !s.done && s.cs_n && !cmd_valid_i) begin
            next_s.rdy = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    assign link.sclk  = s.sclk;
    assign link.cs_n  = s.cs_n;
    assign link.si    = s.si;
    // Upper lines carry the inverse data bit, so a device that mixes them in fails
    assign link.io_hi = {3{!s.si}};
    assign cmd_ready_o = s.rdy;
    assign done_o      = s.done;
    assign cut_o       = s.cut;

endmodule

// File: logic/fru_map.svh
// Opcodes, table image, bit counts and timing counts of the flash command block
`ifndef FRU_MAP_SVH
`define FRU_MAP_SVH

`define FRU_OPC_IDLE    8'h00
`define FRU_OPC_ARM     8'h66
`define FRU_OPC_EXEC    8'h99
`define FRU_OPC_UID     8'h4b
`define FRU_OPC_PTBL    8'h5a

// Bits taken in before read data: opcode, then four address or dummy bytes
`define FRU_OPC_BITS    6'h08
`define FRU_ADDR_END    6'h20
`define FRU_HDR_BITS    6'h28
`define FRU_UID_BYTES   24'h000010
`define FRU_TBL_BYTES   24'h000018
`define FRU_VENDOR_IDX  5'h10
`define FRU_TBL_FILL    8'hff

// Table bytes 17h down to 00h; byte 10h is replaced by the vendor code
`define FRU_TBL_IMAGE   192'hff00006003010000_ff00003009010000_ff01010050444653

// Host link timing: half period of the link clock is FRU_SCLK_HALF + 1 clk_i cycles
`define FRU_SCLK_HALF   2'h3
// Device input synchronisers delay what it sees by two link edges
`define FRU_RX_EDGE     8'h2a
`define FRU_TAIL_EDGES  2'h3
`define FRU_CMD_BITS    40

`endif

// File: logic/fru_pkg.sv
// Types shared by both ends of the flash command link
package fru_pkg;

    typedef struct packed {
        logic [5:0]  cnt;
        logic [7:0]  op;
        logic [23:0] addr;
        logic [2:0]  ocnt;
        logic [6:0]  ob;
        logic        so;
        logic        oe;
    } fru_frm_t;

    typedef struct packed {
        logic     rs1;
        logic     rs2;
        logic     cs1;
        logic     cs2;
        logic     si1;
        logic     si2;
        fru_frm_t frm;
        logic     armed;
        logic     sw_reset;
        logic     abort;
    } fru_dev_st_t;

    typedef enum logic [1:0] {
        FRU_H_IDLE = 2'b00,
        FRU_H_LOAD = 2'b01,
        FRU_H_XFER = 2'b10,
        FRU_H_TAIL = 2'b11
    } fru_hst_t;

    typedef struct packed {
        logic        so1;
        logic        so2;
        logic [1:0]  div;
        logic        sclk;
        logic        cs_n;
        logic        si;
        fru_hst_t    st;
        logic [7:0]  ecnt;
        logic [39:0] tx;
        logic        rd;
        logic        fin;
        logic [7:0]  rxb;
        logic [2:0]  rxc;
        logic [7:0]  left;
        logic [1:0]  tail;
        logic        rdy;
        logic        done;
        logic        cut;
        logic        push;
        logic [7:0]  pdat;
    } fru_host_st_t;

endpackage

// File: logic/fru_if.sv
// Serial link between the host controller and the flash command block
`timescale 1ns/100ps
interface fru_if;
    logic       sclk;
    logic       cs_n;
    logic       si;
    logic [3:1] io_hi;
    logic       so;
    logic       so_oe;
    logic       so_line;

    // Pulled high while the device leaves the data line free
    assign so_line = so_oe ? so : 1'b1;

    modport dev (
        input  sclk,
        input  cs_n,
        input  si,
        input  io_hi,
        output so,
        output so_oe
    );

    modport host (
        output sclk,
        output cs_n,
        output si,
        output io_hi,
        input  so_line
    );
endinterface

// File: logic/fru_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module fru_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)(
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } fru_fifo_st_t;

    fru_fifo_st_t s;
    fru_fifo_st_t next_s;

    logic full;
    logic empty;

    // Extra pointer bit tells full from empty
    assign empty       = (s.wp == s.rp);
    assign full        = (s.wp[AW-1:0] == s.rp[AW-1:0]) && (s.wp[AW] != s.rp[AW]);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = s.mem[s.rp[AW-1:0]];

    always_comb begin
        next_s = s;
        if (in_valid_i && !full) begin
            next_s.mem[s.wp[AW-1:0]] = in_data_i;
            next_s.wp = s.wp + 1'b1;
        end
        if (out_ready_i && !empty) begin
            next_s.rp = s.rp + 1'b1;
        end
        if (!rst_b_i) begin
            next_s.wp = '0;
            next_s.rp = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end
endmodule

// File: logic/fru_dev.sv
// Flash command block: idle, two-step software reset, unique id and parameter table read
//
// Summary of operation
// - Idle command only cancels a pending arm
// - Upper io lines ignored during idle command
// - Executed reset returns all volatile state
// - Reset executes only straight after arm
// - Any other command discards the arm
// - Upper io lines ignored during arm, execute
// - Reset during program or erase aborts it
// - Fixed 128-bit identifier, never writable
// - Id read: opcode, four dummies, 128 bits
// - Table read: opcode, address, dummy, bytes
// - Chip select high ends the table read
// - Revision bytes 00h, 01h at 04h, 05h
// - Header count 01h at byte 06h
// - Bytes 07h, 0Fh, 17h read FFh
// - First header: id, revision, length, pointer
// - Second header: vendor, revision, length, pointer
`timescale 1ns/100ps
`include "fru_map.svh"

module fru_dev
    import fru_pkg::*;
#(
    // Value arbitrary; each part carries its own
    parameter logic [127:0] UNIQUE_ID = 128'h0123456789abcdef_fedcba9876543210,
    // Value arbitrary
    parameter logic [7:0]   VENDOR_ID = 8'h5c
)(
    fru_if.dev             link,
    input  wire logic      rst_b_i,
    input  wire logic      busy_i,
    output logic           sw_reset_o,
    output logic           abort_o,
    output logic           armed_o
);

    fru_dev_st_t s;
    fru_dev_st_t next_s;

    logic [7:0] opc;
    logic [7:0] fetched;
    logic       is_read;
    logic       uid_end;

    // Read byte for the open command at the given byte address
    function automatic logic [7:0] fru_fetch(
        input logic [7:0]  op,
        input logic [23:0] a
    );
        logic [191:0] img;
        logic [7:0]   res;
        img = `FRU_TBL_IMAGE;
        res = `FRU_TBL_FILL;
        if (op == `FRU_OPC_UID) begin
            res = UNIQUE_ID[7'h7f - {a[3:0], 3'h0} -: 8];
        end else if (a < `FRU_TBL_BYTES) begin
            if (a[4:0] == `FRU_VENDOR_IDX) begin
                res = VENDOR_ID;
            end else begin
                res = img[{a[4:0], 3'h0} +: 8];
            end
        end
        return res;
    endfunction

    // A request is a read if it streams data after the header bits
    function automatic logic fru_is_read(input logic [7:0] op);
        return (op == `FRU_OPC_UID) || (op == `FRU_OPC_PTBL);
    endfunction

    assign opc     = {s.frm.op[6:0], s.si2};
    assign is_read = fru_is_read(s.frm.op);
    assign fetched = fru_fetch(s.frm.op, s.frm.addr);
    assign uid_end = (s.frm.op == `FRU_OPC_UID) && (s.frm.addr >= `FRU_UID_BYTES);

    always_comb begin
        next_s          = s;
        next_s.rs1      = rst_b_i;
        next_s.rs2      = s.rs1;
        next_s.cs1      = link.cs_n;
        next_s.cs2      = s.cs1;
        next_s.si1      = link.si;
        next_s.si2      = s.si1;
        next_s.sw_reset = 1'b0;
        next_s.abort    = 1'b0;

        if (s.cs2) begin
            next_s.frm = '0;
        end else begin
            if (s.frm.cnt != `FRU_HDR_BITS) begin
                next_s.frm.cnt = s.frm.cnt + 6'h01;
            end

            if (s.frm.cnt < `FRU_OPC_BITS) begin
                next_s.frm.op = opc;
            end

            if (s.frm.cnt == `FRU_OPC_BITS - 6'h01) begin
                unique case (opc)
                    `FRU_OPC_ARM: begin
                        next_s.armed = 1'b1;
                    end
                    `FRU_OPC_EXEC: begin
                        if (s.armed) begin
                            next_s.armed    = 1'b0;
                            next_s.sw_reset = 1'b1;
                            next_s.abort    = busy_i;
                        end
                    end
                    `FRU_OPC_IDLE: begin
                        next_s.armed = 1'b0;
                    end
                    default: begin
                        next_s.armed = 1'b0;
                    end
                endcase
            end

            if (s.frm.cnt >= `FRU_OPC_BITS && s.frm.cnt < `FRU_ADDR_END
                    && s.frm.op == `FRU_OPC_PTBL) begin
                next_s.frm.addr = {s.frm.addr[22:0], s.si2};
            end

            if (is_read && s.frm.cnt >= `FRU_HDR_BITS - 6'h01) begin
                next_s.frm.ocnt = s.frm.ocnt + 3'h1;
                if (s.frm.ocnt == 3'h0) begin
                    if (uid_end) begin
                        // Identifier exhausted: stop driving
                        next_s.frm.so = 1'b0;
                        next_s.frm.oe = 1'b0;
                        next_s.frm.ob = '0;
                    end else begin
                        next_s.frm.so   = fetched[7];
                        next_s.frm.ob   = fetched[6:0];
                        next_s.frm.oe   = 1'b1;
                        next_s.frm.addr = s.frm.addr + 24'h000001;
                    end
                end else begin
                    next_s.frm.so = s.frm.ob[6] & s.frm.oe;
                    next_s.frm.ob = {s.frm.ob[5:0], 1'b0};
                end
            end
        end

        if (!s.rs2) begin
            next_s.frm      = '0;
            next_s.armed    = 1'b0;
            next_s.sw_reset = 1'b0;
            next_s.abort    = 1'b0;
        end
    end

    // Link logic lives on the link clock; reset and pins arrive through two flops
    always_ff @(posedge link.sclk) begin
        s <= next_s;
    end

    assign link.so    = s.frm.so;
    assign link.so_oe = s.frm.oe;
    assign sw_reset_o = s.sw_reset;
    assign abort_o    = s.abort;
    assign armed_o    = s.armed;

endmodule

// File: sim/fru_assertions.sv
// Link checker: reset sequencing, arm state, read data bits, line release
`timescale 1ns/100ps
`include "fru_map.svh"
module fru_assertions #(
    parameter logic [127:0] UNIQUE_ID = 128'h0,
    parameter logic [7:0]   VENDOR_ID = 8'h0
)(
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       si,
    input wire logic [3:1] io_hi,
    input wire logic       so,
    input wire logic       so_oe,
    input wire logic       so_line,
    input wire logic       rst_b_i,
    input wire logic       busy_i,
    input wire logic       sw_reset_o,
    input wire logic       abort_o,
    input wire logic       armed_o
);
    localparam logic [191:0] TBL = 192'hff00006003010000_ff00003009010000_ff01010050444653;
    logic [7:0]  cnt;
    logic [7:0]  op;
    logic [7:0]  prev_op;
    logic [23:0] addr;
    logic [7:0]  idx;
    logic [23:0] ta;
    logic [7:0]  tbyte;

    // Rise count saturates so that long reads never wrap
    always_ff @(posedge sclk) begin
        if (!rst_b_i) begin
            cnt     <= 8'h00;
            op      <= 8'h00;
            prev_op <= 8'h00;
            addr    <= 24'h000000;
        end else if (cs_n) begin
            cnt <= 8'h00;
        end else begin
            if (cnt == 8'h00) begin
                prev_op <= op;
            end
            if (cnt != 8'hff) begin
                cnt <= cnt + 8'h01;
            end
            if (cnt < 8'h08) begin
                op <= {op[6:0], si};
            end else if (cnt < 8'h20) begin
                addr <= {addr[22:0], si};
            end
        end
    end

    always_comb begin
        idx = cnt - 8'h2a;
        ta  = addr + {19'h00000, idx[7:3]};
        if (ta == 24'h000010) begin
            tbyte = VENDOR_ID;
        end else if (ta < 24'h000018) begin
            tbyte = TBL[{ta[4:0], 3'h0} +: 8];
        end else begin
            tbyte = 8'hff;
        end
    end

    default clocking cb @(posedge sclk); endclocking
    default disable iff (!rst_b_i);

    sequence s_opcode_in;
        cnt == 8'h08;
    endsequence
    sequence s_exec_after_arm;
        s_opcode_in ##0 (op == `FRU_OPC_EXEC && prev_op == `FRU_OPC_ARM);
    endsequence
    sequence s_data_bit;
        !cs_n && cnt >= 8'h2a && cnt != 8'hff;
    endsequence

    property p_reset_cause;
        sw_reset_o |-> op == `FRU_OPC_EXEC && prev_op == `FRU_OPC_ARM;
    endproperty
    property p_reset_fires;
        s_exec_after_arm |-> ##[1:4] sw_reset_o;
    endproperty
    property p_arm_sets;
        s_opcode_in ##0 op == `FRU_OPC_ARM |-> ##[1:4] armed_o;
    endproperty
    property p_disarm;
        s_opcode_in ##0 op != `FRU_OPC_ARM |-> ##[1:4] !armed_o;
    endproperty
    property p_clear;
        sw_reset_o |=> !armed_o;
    endproperty
    property p_abort;
        sw_reset_o && busy_i && $past(busy_i) |-> abort_o;
    endproperty
    property p_abort_only;
        abort_o |-> sw_reset_o && busy_i;
    endproperty
    property p_uid_bits;
        s_data_bit ##0 (op == `FRU_OPC_UID && cnt <= 8'ha9)
            |-> so_oe && so_line == UNIQUE_ID[8'ha9 - cnt];
    endproperty
    property p_tbl_bits;
        s_data_bit ##0 op == `FRU_OPC_PTBL |-> so_oe && so == tbyte[3'h7 - idx[2:0]];
    endproperty
    property p_release;
        cs_n [*5] |-> !so_oe && so_line;
    endproperty

    a_reset_cause: assert property (p_reset_cause) else $error("reset without arm");
    a_reset_fires: assert property (p_reset_fires) else $error("reset missing");
    a_arm_sets: assert property (p_arm_sets) else $error("arm not held");
    a_disarm: assert property (p_disarm) else $error("arm kept");
    a_clear: assert property (p_clear) else $error("arm kept after reset");
    a_abort: assert property (p_abort) else $error("abort missing");
    a_abort_only: assert property (p_abort_only) else $error("stray abort");
    a_uid_bits: assert property (p_uid_bits) else $error("id bit wrong");
    a_tbl_bits: assert property (p_tbl_bits) else $error("table bit wrong");
    a_release: assert property (p_release) else $error("line held");
endmodule

// File: sim/tb_flash_reset_uid_param_read.sv
// Bench: host and flash command block facing each other over the link
`timescale 1ns/100ps
module tb_flash_reset_uid_param_read;
    // Identifier and vendor values arbitrary
    localparam logic [127:0] UID = 128'h8e2b41d0937a5cf60b18e4a27d63c95f;
    localparam logic [7:0]   VID = 8'h3c;
    localparam logic [191:0] TBL = 192'hff00006003010000_ff00003009010000_ff01010050444653;
    logic        clk_i, rst_b_i, dev_rst_b, busy_i;
    logic        cmd_valid_i, cmd_ready_o, rd_valid_o, rd_ready_i;
    logic        done_o, cut_o, sw_reset_o, abort_o, armed_o;
    logic [7:0]  cmd_op_i, cmd_len_i, rd_data_o;
    logic [23:0] cmd_addr_i;
    logic [7:0]  rxq[$];
    int          n_mismatch, checked, n_rst, n_abt;

    fru_if u_fru_if ();
    fru_host u_fru_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(u_fru_if.host),
        .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
        .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .rd_valid_o(rd_valid_o),
        .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .done_o(done_o), .cut_o(cut_o));
    fru_dev #(.UNIQUE_ID(UID), .VENDOR_ID(VID)) u_fru_dev (.link(u_fru_if.dev),
        .rst_b_i(dev_rst_b), .busy_i(busy_i), .sw_reset_o(sw_reset_o),
        .abort_o(abort_o), .armed_o(armed_o));
    fru_assertions #(.UNIQUE_ID(UID), .VENDOR_ID(VID)) u_fru_assertions (
        .sclk(u_fru_if.sclk), .cs_n(u_fru_if.cs_n), .si(u_fru_if.si),
        .io_hi(u_fru_if.io_hi), .so(u_fru_if.so), .so_oe(u_fru_if.so_oe),
        .so_line(u_fru_if.so_line), .rst_b_i(dev_rst_b), .busy_i(busy_i),
        .sw_reset_o(sw_reset_o), .abort_o(abort_o), .armed_o(armed_o));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) rxq.push_back(rd_data_o);
    end

    // Pulses last one link period, so count them on the link clock
    always @(posedge u_fru_if.sclk) begin
        if (sw_reset_o === 1'b1) n_rst++;
        if (abort_o === 1'b1) n_abt++;
    end

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s: %0h not %0h", $time, what, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] tbl_exp(input logic [23:0] a);
        if (a == 24'h000010) return VID;
        if (a >= 24'h000018) return 8'hff;
        return TBL[{a[4:0], 3'h0} +: 8];
    endfunction

    // Request held until the edge where ready is seen high
    task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [7:0] len);
        int i;
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i    <= op;
        cmd_addr_i  <= a;
        cmd_len_i   <= len;
        i = 0;
        do begin
            @(negedge clk_i);
            i++;
        end while (cmd_ready_o !== 1'b1 && i < 4000);
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        do begin
            @(negedge clk_i);
            i++;
        end while (done_o !== 1'b1 && i < 4000);
        if (i >= 4000) begin
            n_mismatch++;
            print_verdict();
        end
    endtask

    task automatic run_reset(input logic [23:0] ops, input int n, input logic busy,
                             input int exp_rst, input int exp_abt);
        @(posedge clk_i);
        busy_i <= busy;
        n_rst = 0;
        n_abt = 0;
        for (int k = 0; k < n; k++) send(ops[23 - 8 * k -: 8], 24'h000000, 8'h01);
        repeat (24) @(negedge clk_i);
        check(128'(n_rst), 128'(exp_rst), "reset pulses");
        check(128'(n_abt), 128'(exp_abt), "abort pulses");
        check(armed_o, 1'b0, "armed after");
    endtask

    task automatic t_uid;
        rxq.delete();
        send(8'h4b, 24'h000000, 8'h10);
        repeat (8) @(negedge clk_i);
        check(128'(rxq.size()), 128'h10, "id count");
        for (int k = 0; k < 16; k++) check(rxq[k], UID[127 - 8 * k -: 8], "id byte");
    endtask

    task automatic t_table(input logic [23:0] a, input logic [7:0] len);
        rxq.delete();
        send(8'h5a, a, len);
        repeat (8) @(negedge clk_i);
        check(128'(rxq.size()), 128'(len), "table count");
        for (int k = 0; k < len; k++) check(rxq[k], tbl_exp(a + 24'(k)), "table");
    endtask

    // Reader stalls so the FIFO fills and the host cuts the read short
    task automatic t_fill;
        @(posedge clk_i);
        rd_ready_i <= 1'b0;
        rxq.delete();
        send(8'h5a, 24'h000000, 8'h14);
        check(cut_o, 1'b1, "cut");
        check(rd_valid_o, 1'b1, "full valid");
        @(posedge clk_i);
        rd_ready_i <= 1'b1;
        repeat (24) @(negedge clk_i);
        check(rd_valid_o, 1'b0, "drained");
        check(128'(rxq.size()), 128'h10, "kept count");
        for (int k = 0; k < 16; k++) check(rxq[k], tbl_exp(24'(k)), "kept");
    endtask

    initial begin
        rst_b_i = 1'b0;
        dev_rst_b = 1'b0;
        busy_i = 1'b0;
        cmd_valid_i = 1'b0;
        cmd_op_i = 8'h00;
        cmd_addr_i = 24'h000000;
        cmd_len_i = 8'h01;
        rd_ready_i = 1'b1;
        n_mismatch = 0;
        checked = 0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // Device reset passes link-clock synchronisers, so it is held longer
        repeat (30) @(posedge clk_i);
        dev_rst_b <= 1'b1;
        repeat (40) @(posedge clk_i);
        t_uid();
        t_table(24'h000000, 8'h18);
        t_table(24'h000016, 8'h04);
        t_fill();
        send(8'h66, 24'h000000, 8'h01);
        check(armed_o, 1'b1, "armed");
        run_reset(24'h009900, 2, 1'b0, 0, 0);
        run_reset(24'h990000, 1, 1'b0, 0, 0);
        run_reset(24'h664b99, 3, 1'b0, 0, 0);
        run_reset(24'h669900, 2, 1'b0, 1, 0);
        run_reset(24'h669900, 2, 1'b1, 1, 1);
        run_reset(24'h669999, 3, 1'b0, 1, 0);
        print_verdict();
    end
endmodule
